// *** rtl/sps_pkg.sv ***
// Package for the serial to parallel shift and store block.
package sps_pkg;
	// Data widths and the capture FIFO depth.
	localparam int         SPS_W        = 16;
	localparam int         SPS_DEPTH    = 16;
	localparam int         SPS_AW       = 4;
	localparam int         SPS_LVL_W    = 5;
	// Register byte offsets.
	localparam logic [3:0] SPS_OFF_CTRL = 4'h0;
	localparam logic [3:0] SPS_OFF_STAT = 4'h4;
	localparam logic [3:0] SPS_OFF_DATA = 4'h8;
	localparam logic [3:0] SPS_OFF_LVL  = 4'hc;
	// Field positions and reset values.
	localparam int         SPS_CAP_BIT  = 0;
	localparam logic [15:0] SPS_REG_RST = 16'h0000;
	localparam logic [1:0] SPS_OKAY     = 2'h0;
	localparam logic [1:0] SPS_SLVERR   = 2'h2;

	// Pin inputs from the host, all sampled on aclk.
	typedef struct packed {
		logic unit_select_n;
		logic direction_select;
		logic shift_clk_fall;
		logic store_clock;
		logic store_clear_n;
		logic serial_in;
	} sps_pins_t;

	// State of the top module, apart from the capture FIFO, which keeps its own.
	typedef struct packed {
		logic        shclk_d;
		logic        stclk_d;
		logic [15:0] shreg;
		logic [15:0] store;
		logic        sout;
		logic        soe;
		logic        push;
		logic        pop;
		logic        cap_en;
		logic        cap_ready;
		logic        aw_got;
		logic [3:0]  awaddr;
		logic        w_got;
		logic [31:0] wdata;
		logic        wstb0;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} sps_state_t;

	// Reset state; the store clock history starts high so reset makes no edge.
	localparam sps_state_t SPS_STATE_RST = '{stclk_d: 1'b1, default: '0};
endpackage

// *** rtl/sps_shift_store.sv ***
// Serial shift register with storage register, capture FIFO and AXI4-Lite slave.
`timescale 1ns/100ps

// Capture FIFO with valid and ready on both sides.
module sps_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int PW = $clog2(DEPTH);
	typedef struct packed {
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0]   cnt;
	} sps_fifo_t;
	sps_fifo_t        f;
	sps_fifo_t        next_f;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             do_wr;
	logic             do_rd;

	// Handshakes on both sides.
	assign in_ready  = f.cnt < (PW+1)'(DEPTH);
	assign out_valid = f.cnt != '0;
	assign out_data  = mem[f.rp];
	assign level     = f.cnt;
	assign do_wr     = in_valid & in_ready;
	assign do_rd     = out_valid & out_ready;

	// Pointer and count update.
	always_comb
	begin
		next_f = f;
		if (do_wr)
			next_f.wp = f.wp + 1'b1;
		if (do_rd)
			next_f.rp = f.rp + 1'b1;
		next_f.cnt = f.cnt + (PW+1)'(do_wr) - (PW+1)'(do_rd);
	end

	// Registers the pointers; the array itself needs no reset.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			f <= '0;
		else
			f <= next_f;
		if (do_wr)
			mem[f.wp] <= in_data;
	end
endmodule

// Operation
// - 16-bit shift and storage registers, storage shown
// - Deselected: no shifting, serial pin released
// - Write direction: pin bit shifts in
// - Read direction: shift out, recirculate bit
// - Drive pin when selected in read direction
// - Read direction, store clock high: reload from storage
// - Act only on shift clock falling edge
// - Clear forces storage low, highest priority
// - Storage holds unless selected write direction
// - Store clock rise copies shift register
module sps_shift_store (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire sps_pkg::sps_pins_t   pins,
	output logic                      serial_out,
	output logic                      serial_oe,
	output logic [15:0]               parallel_outputs,
	output logic                      capture_ready,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [3:0]           awaddr,
	input  wire logic                 wvalid,
	output logic                      wready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	output logic                      bvalid,
	input  wire logic                 bready,
	output logic [1:0]                bresp,
	input  wire logic                 arvalid,
	output logic                      arready,
	input  wire logic [3:0]           araddr,
	output logic                      rvalid,
	input  wire logic                 rready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp
);
	sps_pkg::sps_state_t s;
	sps_pkg::sps_state_t next_s;
	logic                fall;
	logic                rise;
	logic                sel;
	logic                dir;
	logic                f_in_ready;
	logic                f_out_valid;
	logic [15:0]         f_out_data;
	logic [4:0]          f_level;

	// Edge detection on the sampled host clocks.
	assign fall = s.shclk_d & ~pins.shift_clk_fall;
	assign rise = ~s.stclk_d & pins.store_clock;
	assign sel  = ~pins.unit_select_n;
	assign dir  = pins.direction_select;

	// Every output comes straight from the state register.
	assign serial_out       = s.sout;
	assign serial_oe        = s.soe;
	assign parallel_outputs = s.store;
	assign capture_ready    = s.cap_ready;
	assign awready          = s.awready;
	assign wready           = s.wready;
	assign bvalid           = s.bvalid;
	assign bresp            = s.bresp;
	assign arready          = s.arready;
	assign rvalid           = s.rvalid;
	assign rdata            = s.rdata;
	assign rresp            = s.rresp;

	// Captured words wait here until software reads them.
	sps_fifo #(
		.WIDTH (sps_pkg::SPS_W),
		.DEPTH (sps_pkg::SPS_DEPTH)
	) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (s.push),
		.in_ready  (f_in_ready),
		.in_data   (s.store),
		.out_valid (f_out_valid),
		.out_ready (s.pop),
		.out_data  (f_out_data),
		.level     (f_level)
	);

	// Next state of the shift path, the storage path and the bus slave.
	always_comb
	begin
		next_s         = s;
		next_s.push    = 1'b0;
		next_s.pop     = 1'b0;
		next_s.shclk_d = pins.shift_clk_fall;
		next_s.stclk_d = pins.store_clock;
		// Shift register moves only when selected, on a falling edge.
		if (sel && fall)
		begin
			if (!dir)
				next_s.shreg = {s.shreg[14:0], pins.serial_in};
			else if (pins.store_clock)
				next_s.shreg = s.store;
			else
				next_s.shreg = {s.shreg[14:0], s.shreg[15]};
		end
		// Clear beats load; otherwise only the selected write direction loads.
		if (!pins.store_clear_n)
			next_s.store = sps_pkg::SPS_REG_RST;
		else if (sel && !dir && rise)
		begin
			next_s.store = s.shreg;
			next_s.push  = s.cap_en;
		end
		next_s.sout      = next_s.shreg[15];
		next_s.soe       = sel & dir;
		next_s.cap_ready = f_in_ready;
		// Write address and data are taken in either order.
		if (awvalid && s.awready)
		begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = awaddr;
		end
		if (wvalid && s.wready)
		begin
			next_s.w_got = 1'b1;
			next_s.wdata = wdata;
			next_s.wstb0 = wstrb[0];
		end
		if (s.bvalid && bready)
			next_s.bvalid = 1'b0;
		if (s.aw_got && s.w_got && !s.bvalid)
		begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = sps_pkg::SPS_OKAY;
			case (s.awaddr)
				sps_pkg::SPS_OFF_CTRL:
				begin
					if (s.wstb0)
						next_s.cap_en = s.wdata[sps_pkg::SPS_CAP_BIT];
				end
				sps_pkg::SPS_OFF_STAT,
				sps_pkg::SPS_OFF_DATA,
				sps_pkg::SPS_OFF_LVL:
					next_s.bresp = sps_pkg::SPS_OKAY;
				default:
					next_s.bresp = sps_pkg::SPS_SLVERR;
			endcase
		end
		// Reads answer one cycle after the address is taken.
		if (s.rvalid && rready)
			next_s.rvalid = 1'b0;
		if (arvalid && s.arready)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = sps_pkg::SPS_OKAY;
			case (araddr)
				sps_pkg::SPS_OFF_CTRL:
					next_s.rdata = {31'h0, s.cap_en};
				sps_pkg::SPS_OFF_STAT:
					next_s.rdata = {s.store, s.shreg};
				sps_pkg::SPS_OFF_DATA:
				begin
					next_s.rdata = {15'h0, f_out_valid, f_out_data};
					next_s.pop   = f_out_valid;
				end
				sps_pkg::SPS_OFF_LVL:
					next_s.rdata = {27'h0, f_level};
				default:
				begin
					next_s.rdata = 32'h0;
					next_s.rresp = sps_pkg::SPS_SLVERR;
				end
			endcase
		end
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready  = !next_s.w_got && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;
	end

	// State register with synchronous reset.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= sps_pkg::SPS_STATE_RST;
		else
			s <= next_s;
	end

	// Checks on the shift and storage behaviour.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_shift_in;
		sel && !dir && fall;
	endsequence
	sequence s_recirc;
		sel && dir && !pins.store_clock && fall;
	endsequence
	sequence s_reload;
		sel && dir && pins.store_clock && fall;
	endsequence
	sequence s_load;
		pins.store_clear_n && sel && !dir && rise;
	endsequence

	property p_hold_desel;
		pins.unit_select_n |=> s.shreg == $past(s.shreg) ##0 !serial_oe;
	endproperty
	a_hold_desel: assert property (p_hold_desel) else $error("shift moved while deselected");

	property p_shift_in;
		s_shift_in |=> s.shreg == {$past(s.shreg[14:0]), $past(pins.serial_in)};
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in");

	property p_recirc;
		s_recirc |=> s.shreg == {$past(s.shreg[14:0]), $past(s.shreg[15])}
			&& serial_out == s.shreg[15];
	endproperty
	a_recirc: assert property (p_recirc) else $error("recirculation wrong");

	property p_oe;
		##1 serial_oe == ($past(sel) && $past(dir));
	endproperty
	a_oe: assert property (p_oe) else $error("serial driver enable wrong");

	property p_reload;
		s_reload |=> s.shreg == $past(s.store);
	endproperty
	a_reload: assert property (p_reload) else $error("reload from storage wrong");

	property p_no_edge;
		!fall |=> s.shreg == $past(s.shreg);
	endproperty
	a_no_edge: assert property (p_no_edge) else $error("shift without falling edge");

	property p_clear;
		!pins.store_clear_n |=> parallel_outputs == 16'h0000;
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not zero outputs");

	property p_store_hold;
		pins.store_clear_n && (!sel || dir) |=> parallel_outputs == $past(parallel_outputs);
	endproperty
	a_store_hold: assert property (p_store_hold) else $error("storage changed in hold");

	property p_load;
		s_load |=> parallel_outputs == $past(s.shreg);
	endproperty
	a_load: assert property (p_load) else $error("storage load wrong");
endmodule

// *** verif/sps_host.sv ***
// Host model that drives the pin controls and shares the serial line.
`timescale 1ns/100ps
module sps_host (
	input  wire logic          aclk,
	input  wire logic          serial_out,
	input  wire logic          serial_oe,
	output sps_pkg::sps_pins_t pins,
	output logic               line
);
	sps_pkg::sps_pins_t c;
	logic               drv;
	logic               hb;
	logic               last;
	// A released line shows the inverse of its last level, never a stale value.
	always_comb line = serial_oe ? serial_out : (drv ? hb : ~last);
	// Plain clocked process, since the initial block below also sets the history.
	always @(posedge aclk) last <= line;
	assign pins = {c[5:1], line};
	// Deselected, shift in, shift clock high, store clock low, clear released.
	initial
	begin
		c = 6'h2b;
		drv = 1'b0;
		hb = 1'b0;
		last = 1'b0;
	end
	// Each level stands three cycles so every edge is seen and has landed.
	task hold();
		repeat (3) @(posedge aclk);
	endtask
	task mode(input logic sn, input logic dir);
		c.unit_select_n <= sn;
		c.direction_select <= dir;
		drv <= ~dir;
		hold();
	endtask
	task shift(input logic b);
		hb <= b;
		c.shift_clk_fall <= 1'b1;
		hold();
		c.shift_clk_fall <= 1'b0;
		hold();
	endtask
	task store(input logic v);
		c.store_clock <= v;
		hold();
	endtask
	task clear(input logic v);
		c.store_clear_n <= v;
		hold();
	endtask
endmodule

// *** verif/sps_shift_store_tb_top.sv ***
// Testbench for the serial shift and store block.
`timescale 1ns/100ps
module sps_shift_store_tb_top;
	logic               aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic               awready, wready, bvalid, arready, rvalid, soe, so, cr, line;
	logic [3:0]         awaddr, araddr, wstrb;
	logic [31:0]        wdata, rdata, d, r;
	logic [1:0]         bresp, rresp;
	logic [15:0]        po, e, s;
	sps_pkg::sps_pins_t pins;
	int                 fails, tests_run, seed;

	sps_host host (.aclk(aclk), .serial_out(so), .serial_oe(soe), .pins(pins), .line(line));
	sps_shift_store dut (.aclk(aclk), .aresetn(aresetn), .pins(pins), .serial_out(so),
		.serial_oe(soe), .parallel_outputs(po), .capture_ready(cr),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

	// Free running 250 MHz clock.
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// Expected shift: new bit enters at bit 0.
	function automatic logic [15:0] shin(logic [15:0] w, logic b);
		return {w[14:0], b};
	endfunction

	// Expected response: the four mapped offsets answer OKAY, all others SLVERR.
	function automatic logic [1:0] exp_resp(logic [3:0] a);
		if (a == sps_pkg::SPS_OFF_CTRL || a == sps_pkg::SPS_OFF_STAT ||
			a == sps_pkg::SPS_OFF_DATA || a == sps_pkg::SPS_OFF_LVL)
			return sps_pkg::SPS_OKAY;
		return sps_pkg::SPS_SLVERR;
	endfunction

	task chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask

	task done(input int n);
		$display("test %0d done", n);
	endtask

	// Bus write of bit 0 and strobe 0; upper data and strobes are random.
	// Address and data are released each when taken; bready rises at random and then holds.
	task wr(input logic [3:0] a, input logic v, input logic m);
		@(posedge aclk);
		r = $random(seed);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= {r[31:1], v};
		wstrb <= {r[3:1], m};
		bready <= r[4];
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			r = $random(seed);
			if (!bready)
				bready <= r[0];
		end while (!(bvalid && bready));
		bready <= 1'b0;
		chk(bresp, exp_resp(a));
	endtask

	// Bus read into d; rready rises at random and then holds until the answer.
	task rd(input logic [3:0] a);
		@(posedge aclk);
		r = $random(seed);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= r[0];
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			r = $random(seed);
			if (!rready)
				rready <= r[0];
		end while (!(rvalid && rready));
		d = rdata;
		rready <= 1'b0;
		chk(rresp, exp_resp(a));
	endtask

	task finish_test();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Shift in random words, then store, recirculate, reload, fill and clear.
	task shift_word();
		for (int i = 0; i < 16; i++)
		begin
			d = $random(seed);
			e = shin(e, d[0]);
			host.shift(d[0]);
		end
	endtask

	task pulse();
		host.store(1'b1);
		host.store(1'b0);
	endtask

	initial
	begin
		seed = 32'hc0a950cd;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wstrb, wdata} = '0;
		aresetn = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		chk(po, 0);
		chk(soe, 0);
		wr(sps_pkg::SPS_OFF_CTRL, 1'b1, 1'b1);
		host.mode(1'b0, 1'b0);
		e = 16'h0;
		shift_word();
		pulse();
		s = e;
		chk(po, s);
		rd(sps_pkg::SPS_OFF_DATA);
		chk(d, {15'h0, 1'b1, s});
		done(1);
		host.mode(1'b0, 1'b1);
		chk(soe, 1);
		for (int i = 0; i < 16; i++)
		begin
			chk(line, e[15]);
			host.shift(1'b0);
			e = shin(e, e[15]);
		end
		pulse();
		rd(sps_pkg::SPS_OFF_STAT);
		chk(d, {s, s});
		done(2);
		d = $random(seed);
		host.mode(1'b1, d[0]);
		chk(soe, 0);
		host.shift(1'b1);
		pulse();
		rd(sps_pkg::SPS_OFF_STAT);
		chk(d, {s, s});
		done(3);
		host.mode(1'b0, 1'b0);
		shift_word();
		host.mode(1'b0, 1'b1);
		host.store(1'b1);
		host.shift(1'b0);
		host.store(1'b0);
		rd(sps_pkg::SPS_OFF_STAT);
		chk(d, {s, s});
		done(4);
		host.mode(1'b0, 1'b0);
		for (int i = 0; i < 17; i++)
			pulse();
		chk(cr, 0);
		rd(sps_pkg::SPS_OFF_LVL);
		chk(d, 16);
		for (int i = 0; i < 16; i++)
		begin
			rd(sps_pkg::SPS_OFF_DATA);
			chk(d, {15'h0, 1'b1, s});
		end
		rd(sps_pkg::SPS_OFF_DATA);
		chk(d[16], 0);
		chk(cr, 1);
		done(5);
		host.clear(1'b0);
		chk(po, 0);
		host.store(1'b1);
		chk(po, 0);
		host.clear(1'b1);
		host.store(1'b0);
		pulse();
		chk(po, s);
		done(6);
		// Random and unmapped addresses; strobe 0 low leaves capture enabled.
		for (int i = 0; i < 8; i++)
		begin
			d = $random(seed);
			wr(d[3:0], 1'b0, 1'b0);
			rd(d[7:4]);
		end
		wr(4'h6, 1'b0, 1'b1);
		rd(4'h1);
		rd(sps_pkg::SPS_OFF_CTRL);
		chk(d, 1);
		// Capture switched off: a storage load no longer fills the FIFO.
		wr(sps_pkg::SPS_OFF_CTRL, 1'b0, 1'b1);
		rd(sps_pkg::SPS_OFF_CTRL);
		chk(d, 0);
		rd(sps_pkg::SPS_OFF_LVL);
		e = d[15:0];
		pulse();
		rd(sps_pkg::SPS_OFF_LVL);
		chk(d, {16'h0, e});
		done(7);
		finish_test();
	end

	// Watchdog: the tests need well under 50000 cycles.
	initial
	begin
		#200000;
		fails++;
		finish_test();
	end
endmodule
